/* design/uftp_pkg.sv */
package uftp_pkg;

  // ==========================================================================
  // Bus geometry.
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 32;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [11:0] OFS_MODE        = 12'h000;
  localparam logic [11:0] OFS_CTRL        = 12'h004;
  localparam logic [11:0] OFS_TXBUF       = 12'h008;
  localparam logic [11:0] OFS_TXSTAT      = 12'h00C;
  localparam logic [11:0] OFS_RXBUF       = 12'h010;
  localparam logic [11:0] OFS_RXSTAT      = 12'h014;
  localparam logic [11:0] OFS_BAUD        = 12'h018;

  // ==========================================================================
  // Field positions of the operation mode register.
  localparam int unsigned MODE_POWER_BIT  = 7;
  localparam int unsigned MODE_TXE_BIT    = 6;
  localparam int unsigned MODE_RXE_BIT    = 5;
  localparam int unsigned MODE_PS_HI_BIT  = 4;
  localparam int unsigned MODE_PS_LO_BIT  = 3;
  localparam int unsigned MODE_CL_BIT     = 2;
  localparam int unsigned MODE_SL_BIT     = 1;

  // ==========================================================================
  // Field positions of the serial control and status registers.
  localparam int unsigned CTRL_DIR_BIT    = 1;
  localparam int unsigned CTRL_INV_BIT    = 0;
  localparam int unsigned TXSTAT_BUSY_BIT = 0;
  localparam int unsigned TXSTAT_FULL_BIT = 1;
  localparam int unsigned RXSTAT_OVR_BIT  = 0;
  localparam int unsigned RXSTAT_FRM_BIT  = 1;
  localparam int unsigned RXSTAT_PAR_BIT  = 2;
  localparam int unsigned RXSTAT_FULL_BIT = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0]  MODE_RESET      = 8'h01;
  localparam logic [1:0]  CTRL_RESET      = 2'h2;
  localparam logic [15:0] BAUD_RESET      = 16'h043D;

  // ==========================================================================
  // Parity select codes, high bit then low bit.
  localparam logic [1:0]  PAR_NONE        = 2'h0;
  localparam logic [1:0]  PAR_ZERO        = 2'h1;
  localparam logic [1:0]  PAR_ODD         = 2'h2;
  localparam logic [1:0]  PAR_EVEN        = 2'h3;

  // ==========================================================================
  // Frame state machines.
  typedef enum logic [4:0] {
    TX_IDLE   = 5'b00001,
    TX_START  = 5'b00010,
    TX_DATA   = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP   = 5'b10000
  } uftp_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } uftp_rx_state_t;

endpackage : uftp_pkg

/* design/uftp_top.sv */
module uftp_top (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [uftp_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [uftp_pkg::DATA_W-1:0]   pwdata_i,
  input  wire logic [3:0]                    pstrb_i,
  output logic      [uftp_pkg::DATA_W-1:0]   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic                          serial_in_pin_i,
  output logic                               serial_out_pin_o,
  output logic                               tx_pin_assigned_o,
  output logic                               rx_pin_assigned_o,
  output logic                               tx_done_irq_o,
  output logic                               rx_done_irq_o,
  output logic                               rx_error_irq_o
);
  import uftp_pkg::*;

  // ==========================================================================
  // Configuration registers and decoded fields.
  logic [7:0]           operation_mode_reg_q;
  logic [1:0]           serial_control_reg_q;
  logic [15:0]          baud_q;
  logic                 unit_power_enable;
  logic                 tx_enable_bit;
  logic                 rx_enable_bit;
  logic [1:0]           parity_sel;
  logic                 char8;
  logic                 stop2;
  logic                 first_bit_select;
  logic                 tx_invert_select;
  logic [15:0]          baud_max;
  logic [15:0]          baud_half;
  logic                 core_rst;
  logic                 tx_rst;
  logic                 rx_rst;
  logic [2:0]           last_bit;

  assign unit_power_enable = operation_mode_reg_q[MODE_POWER_BIT];
  assign tx_enable_bit     = operation_mode_reg_q[MODE_TXE_BIT];
  assign rx_enable_bit     = operation_mode_reg_q[MODE_RXE_BIT];
  assign parity_sel        = {operation_mode_reg_q[MODE_PS_HI_BIT],
                              operation_mode_reg_q[MODE_PS_LO_BIT]};
  assign char8             = operation_mode_reg_q[MODE_CL_BIT];
  assign stop2             = operation_mode_reg_q[MODE_SL_BIT];
  assign first_bit_select  = serial_control_reg_q[CTRL_DIR_BIT];
  assign tx_invert_select  = serial_control_reg_q[CTRL_INV_BIT];
  assign baud_max          = (baud_q == 16'h0000) ? 16'h0000 : baud_q - 16'h0001;
  assign baud_half         = {1'b0, baud_max[15:1]};
  assign last_bit          = char8 ? 3'h7 : 3'h6;
  assign core_rst          = ~rst_n_i | ~unit_power_enable;
  assign tx_rst            = core_rst | ~tx_enable_bit;
  assign rx_rst            = core_rst | ~rx_enable_bit;

  // ==========================================================================
  // Bit order helper: reverses the character field for MSB-first frames.
  function automatic logic [7:0] order_bits(input logic [7:0] d,
                                            input logic       lsb_first,
                                            input logic       c8);
    logic [7:0] r;
    r = 8'h00;
    if (lsb_first) begin
      r = c8 ? d : {1'b0, d[6:0]};
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (c8) begin
          r[i] = d[7-i];
        end else if (i < 7) begin
          r[i] = d[6-i];
        end
      end
    end
    return r;
  endfunction : order_bits

  // ==========================================================================
  // APB slave decode.
  logic                 acc;
  logic                 wr_ev;
  logic                 rd_ev;
  logic                 hit;
  logic [31:0]          rdata_d;
  logic                 txbuf_full_q;
  logic [7:0]           tx_buffer_q;
  logic [7:0]           rx_buffer_q;
  logic                 rx_full_q;
  logic [2:0]           rx_err_q;
  uftp_tx_state_t       tx_state_q;
  uftp_rx_state_t       rx_state_q;

  assign acc   = psel_i & penable_i & ~pready_o;
  assign wr_ev = acc & pwrite_i;
  assign rd_ev = acc & ~pwrite_i;

  always_comb begin
    hit     = 1'b1;
    rdata_d = 32'h0000_0000;
    unique case (paddr_i)
      OFS_MODE:   rdata_d[7:0]  = operation_mode_reg_q;
      OFS_CTRL:   rdata_d[1:0]  = serial_control_reg_q;
      OFS_TXBUF:  rdata_d[7:0]  = tx_buffer_q;
      OFS_TXSTAT: begin
        rdata_d[TXSTAT_BUSY_BIT] = (tx_state_q != TX_IDLE);
        rdata_d[TXSTAT_FULL_BIT] = txbuf_full_q;
      end
      OFS_RXBUF:  rdata_d[7:0]  = rx_buffer_q;
      OFS_RXSTAT: begin
        rdata_d[2:0]             = rx_err_q;
        rdata_d[RXSTAT_FULL_BIT] = rx_full_q;
      end
      OFS_BAUD:   rdata_d[15:0] = baud_q;
      default:    hit           = 1'b0;
    endcase
  end

  // ==========================================================================
  // APB answer: one wait cycle, then ready with data and error.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc;
      pslverr_o <= acc & ~hit;
      prdata_o  <= rd_ev ? rdata_d : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Software-written configuration.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      operation_mode_reg_q <= MODE_RESET;
      serial_control_reg_q <= CTRL_RESET;
      baud_q               <= BAUD_RESET;
    end else if (wr_ev) begin
      if (paddr_i == OFS_MODE && pstrb_i[0]) begin
        operation_mode_reg_q <= pwdata_i[7:0];
      end
      if (paddr_i == OFS_CTRL && pstrb_i[0]) begin
        serial_control_reg_q <= pwdata_i[1:0];
      end
      if (paddr_i == OFS_BAUD) begin
        if (pstrb_i[0]) begin
          baud_q[7:0] <= pwdata_i[7:0];
        end
        if (pstrb_i[1]) begin
          baud_q[15:8] <= pwdata_i[15:8];
        end
      end
    end
  end

  // ==========================================================================
  // Pin assignment.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_pin_assigned_o <= 1'b0;
      rx_pin_assigned_o <= 1'b0;
    end else begin
      tx_pin_assigned_o <= unit_power_enable & tx_enable_bit;
      rx_pin_assigned_o <= unit_power_enable & rx_enable_bit;
    end
  end

  // ==========================================================================
  // Transmit buffer.
  logic                 tx_load;
  logic                 tx_buf_wr;

  assign tx_load   = (tx_state_q == TX_IDLE) & txbuf_full_q;
  assign tx_buf_wr = wr_ev & (paddr_i == OFS_TXBUF) & pstrb_i[0];

  always_ff @(posedge clock_i) begin
    if (tx_rst) begin
      tx_buffer_q  <= 8'h00;
      txbuf_full_q <= 1'b0;
    end else begin
      if (tx_buf_wr) begin
        tx_buffer_q <= pwdata_i[7:0];
      end
      txbuf_full_q <= tx_buf_wr | (txbuf_full_q & ~tx_load);
    end
  end

  // ==========================================================================
  // Transmit bit timer.
  logic [15:0]          tx_cnt_q;
  logic                 tx_tick;

  assign tx_tick = (tx_cnt_q == 16'h0000);

  always_ff @(posedge clock_i) begin
    if (tx_rst || tx_state_q == TX_IDLE || tx_tick) begin
      tx_cnt_q <= baud_max;
    end else begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
  end

  // ==========================================================================
  // Transmit frame sequencer.
  logic [7:0]           tx_shift_reg_q;
  logic [2:0]           tx_bitn_q;
  logic                 tx_par_q;
  logic                 tx_stopn_q;
  logic                 tx_line_q;
  logic                 tx_ones;
  logic                 tx_par_d;

  assign tx_ones = ^(tx_buffer_q & (char8 ? 8'hFF : 8'h7F));

  always_comb begin
    unique case (parity_sel)
      PAR_EVEN: tx_par_d = tx_ones;
      PAR_ODD:  tx_par_d = ~tx_ones;
      default:  tx_par_d = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (tx_rst) begin
      tx_state_q     <= TX_IDLE;
      tx_shift_reg_q <= 8'h00;
      tx_bitn_q      <= 3'h0;
      tx_par_q       <= 1'b0;
      tx_stopn_q     <= 1'b0;
      tx_line_q      <= 1'b1;
      tx_done_irq_o  <= 1'b0;
    end else begin
      tx_done_irq_o <= 1'b0;
      unique case (tx_state_q)
        TX_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_load) begin
            tx_shift_reg_q <= order_bits(tx_buffer_q, first_bit_select, char8);
            tx_par_q       <= tx_par_d;
            tx_line_q      <= 1'b0;
            tx_state_q     <= TX_START;
          end
        end
        TX_START: begin
          if (tx_tick) begin
            tx_line_q      <= tx_shift_reg_q[0];
            tx_shift_reg_q <= {1'b0, tx_shift_reg_q[7:1]};
            tx_bitn_q      <= 3'h0;
            tx_state_q     <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            if (tx_bitn_q == last_bit) begin
              if (parity_sel == PAR_NONE) begin
                tx_line_q  <= 1'b1;
                tx_stopn_q <= 1'b0;
                tx_state_q <= TX_STOP;
              end else begin
                tx_line_q  <= tx_par_q;
                tx_state_q <= TX_PARITY;
              end
            end else begin
              tx_line_q      <= tx_shift_reg_q[0];
              tx_shift_reg_q <= {1'b0, tx_shift_reg_q[7:1]};
              tx_bitn_q      <= tx_bitn_q + 3'h1;
            end
          end
        end
        TX_PARITY: begin
          if (tx_tick) begin
            tx_line_q  <= 1'b1;
            tx_stopn_q <= 1'b0;
            tx_state_q <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            if (stop2 && !tx_stopn_q) begin
              tx_stopn_q <= 1'b1;
            end else begin
              tx_done_irq_o <= 1'b1;
              tx_state_q    <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Serial output driver.
  always_ff @(posedge clock_i) begin
    if (core_rst || !tx_enable_bit) begin
      serial_out_pin_o <= 1'b1;
    end else begin
      serial_out_pin_o <= tx_line_q ^ tx_invert_select;
    end
  end

  // ==========================================================================
  // Receive input and bit timer.
  logic                 rx_in;
  logic                 rx_prev_q;
  logic [15:0]          rx_cnt_q;
  logic                 rx_tick;

  assign rx_in   = unit_power_enable ? serial_in_pin_i : 1'b1;
  assign rx_tick = (rx_cnt_q == 16'h0000);

  always_ff @(posedge clock_i) begin
    if (rx_rst) begin
      rx_prev_q <= 1'b1;
      rx_cnt_q  <= 16'h0000;
    end else begin
      rx_prev_q <= rx_in;
      if (rx_state_q == RX_IDLE) begin
        rx_cnt_q <= baud_half;
      end else if (rx_tick) begin
        rx_cnt_q <= baud_max;
      end else begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Receive frame sequencer.
  logic [7:0]           rx_shift_q;
  logic [2:0]           rx_bitn_q;
  logic                 rx_par_q;
  logic                 rx_end;
  logic [7:0]           rx_data;
  logic                 rx_ones;
  logic                 rx_par_err;
  logic                 rx_frm_err;

  assign rx_data  = order_bits(char8 ? rx_shift_q : {1'b0, rx_shift_q[7:1]},
                               first_bit_select, char8);
  assign rx_ones  = (^rx_data) ^ rx_par_q;
  assign rx_end   = (rx_state_q == RX_STOP) & rx_tick;
  assign rx_frm_err = rx_end & ~rx_in;

  always_comb begin
    unique case (parity_sel)
      PAR_EVEN: rx_par_err = rx_ones;
      PAR_ODD:  rx_par_err = ~rx_ones;
      default:  rx_par_err = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rx_rst) begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_bitn_q  <= 3'h0;
      rx_par_q   <= 1'b0;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_in) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_bitn_q  <= 3'h0;
            rx_par_q   <= 1'b0;
            rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift_q <= {rx_in, rx_shift_q[7:1]};
            rx_bitn_q  <= rx_bitn_q + 3'h1;
            if (rx_bitn_q == last_bit) begin
              rx_state_q <= (parity_sel == PAR_NONE) ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (rx_tick) begin
            rx_par_q   <= rx_in;
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Receive buffer, error status and completion pulses.
  logic                 rx_buf_rd;
  logic                 rx_stat_rd;
  logic [2:0]           rx_err_new;

  assign rx_buf_rd  = rd_ev & (paddr_i == OFS_RXBUF);
  assign rx_stat_rd = rd_ev & (paddr_i == OFS_RXSTAT);
  assign rx_err_new = {rx_end & rx_par_err, rx_frm_err, rx_end & rx_full_q};

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      rx_buffer_q    <= 8'h00;
      rx_full_q      <= 1'b0;
      rx_err_q       <= 3'h0;
      rx_done_irq_o  <= 1'b0;
      rx_error_irq_o <= 1'b0;
    end else begin
      if (rx_end && !rx_full_q) begin
        rx_buffer_q <= rx_data;
      end
      rx_full_q      <= rx_end | (rx_full_q & ~rx_buf_rd);
      rx_err_q       <= (rx_stat_rd ? 3'h0 : rx_err_q) | rx_err_new;
      rx_done_irq_o  <= rx_end & (rx_err_new == 3'h0);
      rx_error_irq_o <= rx_end & (rx_err_new != 3'h0);
    end
  end

endmodule : uftp_top

/* tb/uftp_sva.sv */
module uftp_sva
  import uftp_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        serial_out_pin_o,
  input wire logic        tx_pin_assigned_o,
  input wire logic        rx_pin_assigned_o,
  input wire logic        tx_done_irq_o,
  input wire logic        rx_done_irq_o,
  input wire logic        rx_error_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Shadow registers; bit timing assumes a divisor of 4.
  logic [7:0] mode_q;
  logic       inv_q;
  logic       inv_prev_q;
  logic       busy_q;
  logic       wr_c;
  logic       md_wr;
  logic       tx_wr;
  logic       stop_lvl;
  assign wr_c     = psel_i && penable_i && pwrite_i && !pready_o;
  assign md_wr    = wr_c && paddr_i == OFS_MODE;
  assign tx_wr    = wr_c && paddr_i == OFS_TXBUF && mode_q[7] && mode_q[6];
  // The output flop applies a control write one cycle late.
  assign stop_lvl = serial_out_pin_o != inv_prev_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_q <= MODE_RESET;
      inv_q  <= CTRL_RESET[0];
    end else if (md_wr) begin
      mode_q <= pwdata_i[7:0];
    end else if (wr_c && paddr_i == OFS_CTRL) begin
      inv_q  <= pwdata_i[0];
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || tx_done_irq_o) begin
      busy_q <= 1'b0;
    end else if (tx_wr) begin
      busy_q <= 1'b1;
    end
  end
  always_ff @(posedge clock_i) begin
    inv_prev_q <= inv_q;
  end
  // ====
  // Properties.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_TX_PIN:
    assert property (md_wr |-> ##2 tx_pin_assigned_o == (mode_q[7] && mode_q[6]))
    else $error("transmit pin ownership wrong");
  AST_RX_PIN:
    assert property (md_wr |-> ##2 rx_pin_assigned_o == (mode_q[7] && mode_q[5]))
    else $error("receive pin ownership wrong");
  AST_IDLE_OFF:
    assert property (!tx_pin_assigned_o && !$past(tx_pin_assigned_o) |-> serial_out_pin_o)
    else $error("released output not high");
  AST_IDLE_ON:
    assert property (tx_pin_assigned_o && $past(tx_pin_assigned_o, 2) && !busy_q |-> stop_lvl)
    else $error("idle output level wrong");
  AST_START:
    assert property (tx_wr && !busy_q |-> ##1 stop_lvl [*2] ##1 !stop_lvl [*4])
    else $error("start bit wrong");
  AST_DONE_STOP:
    assert property (tx_done_irq_o |-> $past(stop_lvl) && (!mode_q[1] || $past(stop_lvl, 7)))
    else $error("stop bits before done wrong");
  AST_DONE_PULSE:
    assert property (tx_done_irq_o |=> !tx_done_irq_o [*8])
    else $error("done pulse too long");
  AST_RX_OFF:
    assert property (!rx_pin_assigned_o && !$past(rx_pin_assigned_o, 2)
                     |-> !(rx_done_irq_o || rx_error_irq_o))
    else $error("receive event while disabled");
endmodule : uftp_sva

bind uftp_top uftp_sva uftp_sva_i (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .serial_out_pin_o, .tx_pin_assigned_o, .rx_pin_assigned_o,
  .tx_done_irq_o, .rx_done_irq_o, .rx_error_irq_o);

/* tb/uftp_node.sv */
module uftp_node (
  input  wire logic clock_i,
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Remote node: sends frames and samples frames mid-bit.
  initial line_o = 1'b1;
  task automatic send(input logic [11:0] f, input int k, input int dv);
    line_o <= 1'b0;
    repeat (dv) @(posedge clock_i);
    for (int i = 0; i < k; i++) begin
      line_o <= f[i];
      repeat (dv) @(posedge clock_i);
    end
    line_o <= 1'b1;
  endtask : send
  task automatic grab(input logic inv, input int k, input int dv, output logic [11:0] f);
    int t;
    t = 0;
    f = 12'hFFF;
    while (line_i !== inv && t < 2000) begin
      @(posedge clock_i);
      t++;
    end
    repeat (dv / 2) @(posedge clock_i);
    for (int i = 0; i < k; i++) begin
      repeat (dv) @(posedge clock_i);
      f[i] = line_i ^ inv;
    end
  endtask : grab
endmodule : uftp_node

/* tb/uftp_top_test.sv */
module uftp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import uftp_pkg::*;
  // ====
  // Bench signals, tables and helpers.
  logic        clock_i, rst_n_i, psel_i, penable_i, pwrite_i, serial_in_pin_i, rerr;
  logic [11:0] paddr_i, fe, fg;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, serial_out_pin_o, tx_pin_assigned_o, rx_pin_assigned_o;
  logic        tx_done_irq_o, rx_done_irq_o, rx_error_irq_o;
  logic [7:0]  d, cfg, c;
  logic [1:0]  irq;
  int          bad_count, checks_done, n;
  logic [23:0] tx_tab[6] = '{24'h551C02, 24'h551C00, 24'h551C01, 24'h361202, 24'h870402,
                             24'hA30E03};
  logic [23:0] rx_tab[7] = '{24'h551C08, 24'h551C1C, 24'h361008, 24'h36101C, 24'hA30C18,
                             24'h870408, 24'hA31C28};
  uftp_top uftp_top_i (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .serial_in_pin_i, .serial_out_pin_o,
    .tx_pin_assigned_o, .rx_pin_assigned_o, .tx_done_irq_o, .rx_done_irq_o, .rx_error_irq_o);
  uftp_node uftp_node_i (.clock_i, .line_i(serial_out_pin_o), .line_o(serial_in_pin_i));
  function automatic int mkf(input logic [7:0] dv, input logic [7:0] m, input logic msb,
                             output logic [11:0] f);
    int k;
    logic p;
    k = m[2] ? 8 : 7;
    p = ^(dv & (m[2] ? 8'hFF : 8'h7F));
    f = 12'hFFF;
    for (int i = 0; i < k; i++) begin
      f[i] = msb ? dv[k-1-i] : dv[i];
    end
    if (m[4:3] != PAR_NONE) begin
      f[k] = m[4] && (m[3] ? p : !p);
      k++;
    end
    return k + 1 + m[1];
  endfunction : mkf
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk_frame(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t frame got %h exp %h", $time, got, exp);
    end
  endtask : chk_frame
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clock_i);
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= v;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ====
  // Clock, watchdog and tests.
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i} = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'hF;
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    xfer(1'b0, OFS_MODE, 32'h0);
    chk32(rdat, 32'h1);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk32(rdat, 32'h2);
    xfer(1'b0, 12'h01C, 32'h0);
    chk32({rdat[30:0], rerr}, 32'h1);
    xfer(1'b1, OFS_BAUD, 32'h4);
    xfer(1'b1, OFS_MODE, 32'h80);
    repeat (2) @(posedge clock_i);
    chk32({29'h0, tx_pin_assigned_o, rx_pin_assigned_o, serial_out_pin_o}, 32'h1);
    xfer(1'b1, OFS_MODE, 32'hE0);
    repeat (2) @(posedge clock_i);
    chk32({29'h0, tx_pin_assigned_o, rx_pin_assigned_o, serial_out_pin_o}, 32'h7);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      {d, cfg, c} = tx_tab[i];
      xfer(1'b1, OFS_MODE, {24'h0, 8'h80 | cfg});
      xfer(1'b1, OFS_CTRL, {24'h0, c});
      xfer(1'b1, OFS_MODE, {24'h0, 8'hE0 | cfg});
      n = mkf(d, cfg, !c[1], fe);
      repeat (2) @(posedge clock_i);
      fork
        xfer(1'b1, OFS_TXBUF, {24'h0, d});
        uftp_node_i.grab(c[0], n, 4, fg);
      join
      chk_frame(fg, fe);
      repeat (8) @(posedge clock_i);
    end
    $display("test transmit done");
    for (int i = 0; i < 7; i++) begin
      {d, cfg, c} = rx_tab[i];
      xfer(1'b1, OFS_CTRL, {30'h0, !c[5], 1'b0});
      xfer(1'b1, OFS_MODE, {24'h0, 8'hE0 | cfg});
      n = mkf(d, cfg, c[5], fe);
      fe[cfg[2] ? 8 : 7] ^= c[4];
      irq = 2'h0;
      fork
        uftp_node_i.send(fe, n, 4);
        for (int t = 0; t < 400 && irq === 2'h0; t++) begin
          @(posedge clock_i);
          irq = {rx_error_irq_o, rx_done_irq_o};
        end
      join
      chk32({30'h0, irq}, c[2] ? 32'h2 : 32'h1);
      xfer(1'b0, OFS_RXSTAT, 32'h0);
      chk32(rdat, {28'h0, c[3:0]});
      xfer(1'b0, OFS_RXBUF, 32'h0);
      chk32(rdat, {24'h0, d & (cfg[2] ? 8'hFF : 8'h7F)});
    end
    $display("test receive done");
    tally_and_finish();
  end
endmodule : uftp_top_test
